//--- include/lamp_pkg.sv
// Package: constants and types for the probe status lamp logic
package lamp_pkg;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SLOW_BLINK_HZ = 1;
    localparam int unsigned FAST_BLINK_HZ = 5;
    // Half period of each blink rate, in clock cycles
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
    // Activity flicker half period (fixed, fast enough to be seen as flicker)
    localparam int unsigned FLICK_HALF_CYC = 6_000_000;

    // --------------------------------------------------------------
    // Lamp colour codes {red, green}
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        COL_OFF    = 2'h0,
        COL_GREEN  = 2'h1,
        COL_RED    = 2'h2,
        COL_ORANGE = 2'h3
    } colour_t;

    // --------------------------------------------------------------
    // Host-link lamp states, one-hot
    // --------------------------------------------------------------
    typedef enum logic [5:0] {
        HL_BOOT    = 6'h01,
        HL_CONFIG  = 6'h02,
        HL_READY   = 6'h04,
        HL_UPDATE  = 6'h08,
        HL_TRAFFIC = 6'h10,
        HL_FAULT   = 6'h20
    } hl_state_t;

    // Target execution classes
    typedef enum logic [1:0] {
        TGT_RUN   = 2'h0,
        TGT_PAUSE = 2'h1,
        TGT_MIXED = 2'h2
    } tgt_mode_t;
endpackage

//--- verilog/blink_divider.sv
// Module: square-wave blink generator driven by a cycle-count half period
`timescale 1ns/100ps
`default_nettype none
module blink_divider #(
    parameter int unsigned HALF_CYC = 100_000_000
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Wave
    output logic      wave
);
    localparam int W = $clog2(HALF_CYC + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         wave;
    } div_t;

    div_t st_reg;
    div_t st_next;

    // --------------------------------------------------------------
    // Equal on and off halves
    // --------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt == W'(HALF_CYC - 1)) begin // R16
            st_next.cnt  = '0;
            st_next.wave = ~st_reg.wave;
        end else begin
            st_next.cnt = st_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wave = st_reg.wave;
endmodule // blink_divider
`default_nettype wire

//--- verilog/probe_status_lamps.sv
// Module: status lamp logic of the debug probe
// Behaviour
// R1 - Host-link lamp steady red until boot runs
// R2 - Interface configuring: orange blink at 1 Hz
// R3 - Interface configured: green blink at 1 Hz
// R4 - Firmware update: green blink at 5 Hz
// R5 - Target traffic: host-link lamp blinks orange
// R6 - No target power: target lamp dark
// R7 - Target lamp green run, red pause, orange mixed
// R8 - Target lamp dark until host-link lamp blinks
// R9 - Attached session: exactly one of three states
// R10 - All run, all halted, or mixed
// R11 - Yellow jack lamp on link, flickers on traffic
// R12 - Green jack lamp on fast link, flickers
// R13 - USB presents serial and Ethernet functions
// R14 - Operator powers probe, target, then debugger
// R15 - Remote terminal gets banner then prompt
// R16 - Orange is red plus green, even blinking
// R17 - Update beats traffic, traffic beats ready
`timescale 1ns/100ps
`default_nettype none
module probe_status_lamps #(
    parameter int unsigned NUM_CORES = 4,
    parameter int unsigned SLOW_HALF = lamp_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = lamp_pkg::FAST_HALF_CYC,
    parameter int unsigned FLICK_HALF = lamp_pkg::FLICK_HALF_CYC
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Firmware progress (same clock)
    input  wire logic                 boot_running,
    input  wire logic                 if_configuring,
    input  wire logic                 if_configured,
    input  wire logic                 fw_updating,
    input  wire logic                 target_traffic,
    input  wire logic                 session_attached,
    input  wire logic                 usb_enumerated,
    input  wire logic                 telnet_connect,
    // Target pins (asynchronous)
    input  wire logic                 tgt_power_pin,
    input  wire logic [NUM_CORES-1:0] core_halted_pin,
    // Network PHY pins (asynchronous)
    input  wire logic                 phy_link_pin,
    input  wire logic                 phy_fast_pin,
    input  wire logic                 phy_activity_pin,
    // Host-link lamp
    output logic                      hl_red,
    output logic                      hl_green,
    // Target-state lamp
    output logic                      ts_red,
    output logic                      ts_green,
    // Jack indicators
    output logic                      jack_yellow,
    output logic                      jack_green,
    // Target class and console/USB status
    output logic [1:0]                tgt_mode,
    output logic                      usb_serial_fn,
    output logic                      usb_ether_fn,
    output logic                      console_banner,
    output logic                      console_prompt
);
    localparam int SW = 4 + NUM_CORES;

    typedef struct packed {
        logic [SW-1:0]        sync1;
        logic [SW-1:0]        sync2;
        lamp_pkg::hl_state_t  hl;
        logic                 blinked;
        logic [1:0]           hl_col;
        logic [1:0]           ts_col;
        logic                 jy;
        logic                 jg;
        logic [1:0]           mode;
        logic                 usb_s;
        logic                 usb_e;
        logic                 banner;
        logic                 prompt;
    } st_t;

    st_t st_reg;
    st_t st_next;

    logic slow_wave;
    logic fast_wave;
    logic flick_wave;

    // --------------------------------------------------------------
    // Blink sources
    // --------------------------------------------------------------
    blink_divider #(.HALF_CYC(SLOW_HALF)) u_slow (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wave    (slow_wave)
    );
    blink_divider #(.HALF_CYC(FAST_HALF)) u_fast (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wave    (fast_wave)
    );
    blink_divider #(.HALF_CYC(FLICK_HALF)) u_flick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wave    (flick_wave)
    );

    // Gate a colour with a blink phase
    function automatic logic [1:0] gate_col(input logic [1:0] c, input logic on);
        gate_col = on ? c : lamp_pkg::COL_OFF;
    endfunction

    // All pins share the two sync stages held in the state struct.
    // Cores are synchronised bit by bit, so a change may show mixed for a cycle
    logic [SW-1:0] pins;
    assign pins = {tgt_power_pin, phy_activity_pin, phy_fast_pin, phy_link_pin,
        core_halted_pin};

    logic tgt_pwr_s;
    assign tgt_pwr_s = st_reg.sync2[NUM_CORES+3];

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        logic [NUM_CORES-1:0] halted;
        logic                 link;
        logic                 fast;
        logic                 act;
        halted  = st_reg.sync2[NUM_CORES-1:0];
        link    = st_reg.sync2[NUM_CORES];
        fast    = st_reg.sync2[NUM_CORES+1];
        act     = st_reg.sync2[NUM_CORES+2];
        st_next = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;

        // Host-link state, priority update > traffic > ready
        if (!boot_running) begin
            st_next.hl = lamp_pkg::HL_BOOT; // R1
        end else if (fw_updating) begin
            st_next.hl = lamp_pkg::HL_UPDATE; // R17
        end else if (target_traffic) begin
            st_next.hl = lamp_pkg::HL_TRAFFIC; // R17
        end else if (if_configured) begin
            st_next.hl = lamp_pkg::HL_READY;
        end else begin
            st_next.hl = lamp_pkg::HL_CONFIG;
        end

        case (st_reg.hl)
            lamp_pkg::HL_BOOT:    st_next.hl_col = lamp_pkg::COL_RED; // R1
            lamp_pkg::HL_CONFIG:  st_next.hl_col = gate_col(lamp_pkg::COL_ORANGE, slow_wave); // R2
            lamp_pkg::HL_READY:   st_next.hl_col = gate_col(lamp_pkg::COL_GREEN, slow_wave); // R3
            lamp_pkg::HL_UPDATE:  st_next.hl_col = gate_col(lamp_pkg::COL_GREEN, fast_wave); // R4
            lamp_pkg::HL_TRAFFIC: st_next.hl_col = gate_col(lamp_pkg::COL_ORANGE, slow_wave); // R5
            default:              st_next.hl_col = lamp_pkg::COL_RED;
        endcase

        // Target lamp held dark until the host-link lamp has left boot
        if (st_reg.hl != lamp_pkg::HL_BOOT) begin
            st_next.blinked = 1'b1; // R8
        end

        // Classification: run / pause / mixed
        if (&halted) begin
            st_next.mode = lamp_pkg::TGT_PAUSE; // R10
        end else if (~|halted) begin
            st_next.mode = lamp_pkg::TGT_RUN; // R10
        end else begin
            st_next.mode = lamp_pkg::TGT_MIXED; // R9
        end

        if (!st_reg.blinked || !tgt_pwr_s || !session_attached) begin
            st_next.ts_col = lamp_pkg::COL_OFF; // R6 R8
        end else begin
            case (st_reg.mode)
                lamp_pkg::TGT_RUN:   st_next.ts_col = lamp_pkg::COL_GREEN; // R7
                lamp_pkg::TGT_PAUSE: st_next.ts_col = lamp_pkg::COL_RED; // R7
                default:             st_next.ts_col = lamp_pkg::COL_ORANGE; // R7
            endcase
        end

        // Jack indicators; traffic blanks the lamp on flicker phase
        st_next.jy = link & ~(act & flick_wave); // R11
        st_next.jg = link & fast & ~(act & flick_wave); // R12

        // USB functions and console
        st_next.usb_s  = usb_enumerated; // R13
        st_next.usb_e  = usb_enumerated; // R13
        st_next.banner = telnet_connect; // R15
        st_next.prompt = st_reg.banner; // R15
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg        <= '0;
            st_reg.hl     <= lamp_pkg::HL_BOOT;
            st_reg.hl_col <= lamp_pkg::COL_RED; // R1
        end else begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs: orange drives both elements
    // --------------------------------------------------------------
    assign hl_red         = st_reg.hl_col[1]; // R16
    assign hl_green       = st_reg.hl_col[0]; // R16
    assign ts_red         = st_reg.ts_col[1];
    assign ts_green       = st_reg.ts_col[0];
    assign jack_yellow    = st_reg.jy;
    assign jack_green     = st_reg.jg;
    assign tgt_mode       = st_reg.mode;
    assign usb_serial_fn  = st_reg.usb_s;
    assign usb_ether_fn   = st_reg.usb_e;
    assign console_banner = st_reg.banner;
    assign console_prompt = st_reg.prompt;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_boot_red;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_reg.hl == lamp_pkg::HL_BOOT) |=> (hl_red && !hl_green);
    endproperty
    a_boot_red: assert property (p_boot_red) else $error("boot lamp not red"); // R1

    property p_no_power_dark;
        @(posedge sys_clk) disable iff (!arst_n)
        !tgt_pwr_s |=> (!ts_red && !ts_green);
    endproperty
    a_no_power_dark: assert property (p_no_power_dark) else $error("target lamp lit unpowered"); // R6

    property p_dark_before_blink;
        @(posedge sys_clk) disable iff (!arst_n)
        !st_reg.blinked |=> (!ts_red && !ts_green);
    endproperty
    a_dark_before_blink: assert property (p_dark_before_blink) else $error("target lamp early"); // R8

    property p_mode_legal;
        @(posedge sys_clk) disable iff (!arst_n)
        session_attached |-> (tgt_mode != 2'h3);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal target mode"); // R9

    property p_all_halt_pause;
        @(posedge sys_clk) disable iff (!arst_n)
        (&st_reg.sync2[NUM_CORES-1:0]) |=> (tgt_mode == lamp_pkg::TGT_PAUSE);
    endproperty
    a_all_halt_pause: assert property (p_all_halt_pause) else $error("pause not reported"); // R10

    property p_update_fast;
        @(posedge sys_clk) disable iff (!arst_n)
        (st_reg.hl == lamp_pkg::HL_UPDATE) |=> !hl_red;
    endproperty
    a_update_fast: assert property (p_update_fast) else $error("update lamp not green"); // R4

    property p_priority;
        @(posedge sys_clk) disable iff (!arst_n)
        (boot_running && fw_updating && target_traffic) |=> (st_reg.hl == lamp_pkg::HL_UPDATE);
    endproperty
    a_priority: assert property (p_priority) else $error("update lost priority"); // R17

    property p_green_jack;
        @(posedge sys_clk) disable iff (!arst_n)
        jack_green |-> $past(st_reg.sync2[NUM_CORES]);
    endproperty
    a_green_jack: assert property (p_green_jack) else $error("green jack without link"); // R12

    property p_prompt_after_banner;
        @(posedge sys_clk) disable iff (!arst_n)
        console_banner |=> console_prompt;
    endproperty
    a_prompt_after_banner: assert property (p_prompt_after_banner) else $error("no prompt"); // R15

    c_update:  cover property (@(posedge sys_clk) st_reg.hl == lamp_pkg::HL_UPDATE);
    c_mixed:   cover property (@(posedge sys_clk) ts_red && ts_green);
    c_traffic: cover property (@(posedge sys_clk) st_reg.hl == lamp_pkg::HL_TRAFFIC);
    c_config:  cover property (@(posedge sys_clk) if_configuring && st_reg.hl == lamp_pkg::HL_CONFIG);
endmodule // probe_status_lamps
`default_nettype wire

//--- test/target_cores.sv
// Partner model: target cores with switchable power and delayed halt response
`timescale 1ns/100ps
`default_nettype none
module target_cores #(
    parameter int unsigned NUM_CORES = 4
) (
    // Clock and bench control
    input  wire logic                 sys_clk,
    input  wire logic                 pwr_on,
    input  wire logic [NUM_CORES-1:0] halt_cmd,
    input  wire logic [1:0]           lag,
    // Target pins
    output logic                      tgt_power_pin,
    output logic [NUM_CORES-1:0]      core_halted_pin
);
    // ----------------------------------------------------------
    // Cores
    // ----------------------------------------------------------
    logic [NUM_CORES-1:0] pipe [4];
    logic [NUM_CORES-1:0] junk = '0;
    // A slow target takes up to four cycles to show a halt or resume
    always @(posedge sys_clk) begin
        pipe[0] <= halt_cmd;
        for (int i = 1; i < 4; i++) begin
            pipe[i] <= pipe[i-1];
        end
        junk <= ~junk;
    end
    assign tgt_power_pin = pwr_on;
    // Unpowered status lines float, so show a pattern that keeps changing
    assign core_halted_pin = pwr_on ? pipe[lag] : junk;
endmodule // target_cores
`default_nettype wire

//--- test/probe_status_indicator_logic_tb_top.sv
// Testbench: self-checking bench for the probe status lamps
`timescale 1ns/100ps
`default_nettype none
module probe_status_indicator_logic_tb_top;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam int NC = 4;
    localparam int SH = 10;
    localparam int FH = 2;
    localparam int FL = 3;
    typedef struct {
        int          kind;
        logic [11:0] exp;
        logic [11:0] mask;
        int          n;
    } note_t;
    logic sys_clk = 1'b0, arst_n = 1'b0, boot_running = 1'b0;
    logic if_configuring = 1'b0, if_configured = 1'b0, fw_updating = 1'b0;
    logic target_traffic = 1'b0, session_attached = 1'b0, usb_enumerated = 1'b0;
    logic telnet_connect = 1'b0, phy_link_pin = 1'b0, phy_fast_pin = 1'b0;
    logic phy_activity_pin = 1'b0, pwr_on = 1'b0, busy = 1'b0;
    logic [NC-1:0] halt_cmd = '0;
    logic [1:0]    lag = 2'h0;
    wire logic tgt_power_pin, hl_red, hl_green, ts_red, ts_green;
    wire logic jack_yellow, jack_green, usb_serial_fn, usb_ether_fn;
    wire logic console_banner, console_prompt;
    wire logic [NC-1:0] core_halted_pin;
    wire logic [1:0]    tgt_mode;
    wire logic [11:0]   outs = {hl_red, hl_green, ts_red, ts_green, jack_yellow,
        jack_green, tgt_mode, usb_serial_fn, usb_ether_fn, console_banner, console_prompt};
    int    err_total = 0;
    int    checks_done = 0;
    note_t q[$];
    always #2.5 sys_clk = ~sys_clk;
    // Short blink periods keep the run brief; expectations scale with them
    probe_status_lamps #(.NUM_CORES(NC), .SLOW_HALF(SH), .FAST_HALF(FH), .FLICK_HALF(FL))
    uut (.sys_clk, .arst_n, .boot_running, .if_configuring, .if_configured, .fw_updating,
        .target_traffic, .session_attached, .usb_enumerated, .telnet_connect,
        .tgt_power_pin, .core_halted_pin, .phy_link_pin, .phy_fast_pin, .phy_activity_pin,
        .hl_red, .hl_green, .ts_red, .ts_green, .jack_yellow, .jack_green, .tgt_mode,
        .usb_serial_fn, .usb_ether_fn, .console_banner, .console_prompt);
    target_cores #(.NUM_CORES(NC)) tgt (.sys_clk, .pwr_on, .halt_cmd, .lag,
        .tgt_power_pin, .core_halted_pin);
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task go(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task snap(input logic [11:0] e, input logic [11:0] m);
        q.push_back('{0, e, m, 0});
    endtask
    // Kind 1 watches the host-link lamp, kind 2 the jack pair
    task win(input int k, input logic [3:0] set, input logic [7:0] tr, input int n);
        q.push_back('{k, {tr, set}, 12'h000, n});
    endtask
    task sync;
        @(negedge sys_clk);
        while (q.size() > 0 || busy) @(negedge sys_clk);
    endtask
    function automatic logic [1:0] pair(input int k);
        return (k == 1) ? {hl_red, hl_green} : {jack_yellow, jack_green};
    endfunction
    // ----------------------------------------------------------
    // Monitor
    // ----------------------------------------------------------
    note_t      nt;
    logic [1:0] pr;
    logic [3:0] seen;
    int         tr;
    int         d;
    always begin
        @(negedge sys_clk);
        #1;
        if (q.size() > 0) begin
            busy = 1'b1;
            nt = q.pop_front();
            if (nt.kind == 0) begin
                check(outs & nt.mask, nt.exp);
            end else begin
                pr = pair(nt.kind);
                seen = 4'h0;
                seen[pr] = 1'b1;
                tr = 0;
                repeat (nt.n) begin
                    @(negedge sys_clk);
                    #1;
                    if (pair(nt.kind) !== pr) tr++;
                    pr = pair(nt.kind);
                    seen[pr] = 1'b1;
                end
                check({8'h00, seen}, {8'h00, nt.exp[3:0]});
                // Divider phase is free running, so allow one edge of slack
                d = tr - int'(nt.exp[11:4]);
                check({4'h0, (d >= -1 && d <= 1) ? nt.exp[11:4] : 8'(tr)}, {4'h0, nt.exp[11:4]});
            end
            busy = 1'b0;
        end
    end
    // ----------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------
    logic [NC-1:0] hc;
    logic [1:0]    em;
    logic [1:0]    ec;
    initial begin
        void'($urandom(98526));
        go(5);
        snap(12'h800, 12'hfff); sync;
        arst_n = 1'b1;
        pwr_on = 1'b1;
        halt_cmd = 4'hf;
        go(2);
        session_attached = 1'b1;
        go(10);
        snap(12'h800, 12'hf00); sync;
        win(1, 4'b0100, 8'd0, 20); sync;
        boot_running = 1'b1;
        if_configuring = 1'b1;
        go(4);
        win(1, 4'b1001, 8'(40 / SH), 40); sync;
        for (int i = 0; i < 12; i++) begin
            hc = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            halt_cmd = hc;
            lag = 2'($urandom);
            em = (hc == 4'hf) ? lamp_pkg::TGT_PAUSE : (hc == 4'h0) ? lamp_pkg::TGT_RUN
                : lamp_pkg::TGT_MIXED;
            ec = (hc == 4'hf) ? lamp_pkg::COL_RED : (hc == 4'h0) ? lamp_pkg::COL_GREEN
                : lamp_pkg::COL_ORANGE;
            go(12);
            snap({2'b00, ec, 2'b00, em, 4'h0}, 12'h330); sync;
        end
        pwr_on = 1'b0;
        go(8);
        snap(12'h000, 12'h300); sync;
        pwr_on = 1'b1;
        session_attached = 1'b0;
        go(8);
        snap(12'h000, 12'h300); sync;
        session_attached = 1'b1;
        if_configuring = 1'b0;
        if_configured = 1'b1;
        go(4);
        win(1, 4'b0011, 8'(40 / SH), 40); sync;
        fw_updating = 1'b1;
        target_traffic = 1'b1;
        go(4);
        win(1, 4'b0011, 8'(40 / FH), 40); sync;
        fw_updating = 1'b0;
        go(4);
        win(1, 4'b1001, 8'(40 / SH), 40); sync;
        phy_link_pin = 1'b1;
        go(6);
        snap(12'h080, 12'h0c0); sync;
        phy_fast_pin = 1'b1;
        go(6);
        snap(12'h0c0, 12'h0c0); sync;
        phy_activity_pin = 1'b1;
        go(6);
        win(2, 4'b1001, 8'(30 / FL), 30); sync;
        phy_link_pin = 1'b0;
        phy_fast_pin = 1'b0;
        phy_activity_pin = 1'b0;
        go(6);
        snap(12'h000, 12'h0c0); sync;
        usb_enumerated = 1'b1;
        go(2);
        snap(12'h00c, 12'h00c); sync;
        telnet_connect = 1'b1;
        go(1);
        telnet_connect = 1'b0;
        snap(12'h002, 12'h003);
        go(1);
        snap(12'h001, 12'h003); sync;
        boot_running = 1'b0;
        go(4);
        win(1, 4'b0100, 8'd0, 20); sync;
        // Reset again mid-run: the sticky target-lamp enable must clear
        arst_n = 1'b0;
        go(1);
        snap(12'h800, 12'hfff); sync;
        arst_n = 1'b1;
        go(6);
        snap(12'h800, 12'hf00); sync;
        close_out();
    end
    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #50000;
        err_total++;
        close_out();
    end
endmodule // probe_status_indicator_logic_tb_top
`default_nettype wire
